// *** src/pbs_pkg.sv ***
package pbs_pkg;
    // ----------------------------------------
    // Configuration offsets
    // ----------------------------------------
    localparam logic [7:0]  CMD_OFFSET        = 8'h04;
    localparam logic [7:0]  STATUS_OFFSET     = 8'h06;
    // ----------------------------------------
    // Status field positions
    // ----------------------------------------
    localparam int          POISONED_RX_BIT   = 15;
    localparam int          ERR_MSG_BIT       = 14;
    localparam int          UR_CPL_BIT        = 13;
    localparam int          CA_RX_BIT         = 12;
    localparam int          CA_SIG_BIT        = 11;
    localparam int          MASTER_POISON_BIT = 8;
    localparam int          CAP_LIST_BIT      = 4;
    // ----------------------------------------
    // Command field positions
    // ----------------------------------------
    localparam int          PARITY_RESP_BIT   = 6;
    localparam int          SYSTEM_ERROR_EN_BIT = 8;
    // ----------------------------------------
    // Reset values and masks
    // ----------------------------------------
    localparam logic [15:0] STATUS_RESET      = 16'h0010;
    localparam logic [15:0] STATUS_FIXED      = 16'h0010;
    localparam logic [15:0] STATUS_W1C_MASK   = 16'hF900;
endpackage

// *** src/pbs_status_reg.sv ***
// Summary of operation
// - Poisoned TLP received sets bit 15 regardless of parity response enable.
// - Fatal/nonfatal message sent with system error enable sets bit 14.
// - Completion with unsupported request status received sets bit 13.
// - Completion with completer abort status received sets bit 12.
// - Request completed with completer abort status sets bit 11.
// - Select timing bits 10:9 read zero.
// - With parity response enabled, poisoned completion or poisoned write sets bit 8.
// - Fast back-to-back bit 7 reads zero.
// - High-speed capable bit 5 reads zero.
// - Capability list bit 4 reads one.
// - Interrupt status bit 3 reads zero.
// - Reserved bits 6 and 2:0 read zero.
// - Parity response enable is command bit 6; gates only bit 8.
`timescale 1ns/10ps
`default_nettype none
module pbs_status_reg
    import pbs_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rstn_in,
    input  wire logic        cfg_wr_in,
    input  wire logic [7:0]  cfg_addr_in,
    input  wire logic [1:0]  cfg_be_in,
    input  wire logic [15:0] cfg_wdata_in,
    input  wire logic        parity_response_enable_in,
    input  wire logic        system_error_enable_in,
    input  wire logic        poisoned_tlp_rx_in,
    input  wire logic        poisoned_cpl_data_rx_in,
    input  wire logic        write_req_poisoned_in,
    input  wire logic        error_msg_sent_in,
    input  wire logic        ur_cpl_rx_in,
    input  wire logic        ca_cpl_rx_in,
    input  wire logic        ca_cpl_sent_in,
    output logic      [15:0] status_out
);
    // ----------------------------------------
    // Local helpers
    // ----------------------------------------
    // Clear request of one byte lane; a disabled lane clears nothing
    function automatic logic [7:0] lane_clear(input logic       lane_en,
                                              input logic [7:0] lane_data);
        logic [7:0] result;
        result = lane_en ? lane_data : 8'h00;
        return result;
    endfunction

    // Set wins, so an event racing a clear is never lost
    function automatic logic next_flag(input logic flag,
                                       input logic set_evt,
                                       input logic clr_req);
        logic result;
        result = set_evt | (flag & ~clr_req);
        return result;
    endfunction

    // Flags in order 15,14,13,12,11,8; all other bits hardwired
    function automatic logic [15:0] pack_status(input logic [5:0] flags);
        logic [15:0] word;
        word                    = STATUS_FIXED;
        word[POISONED_RX_BIT]   = flags[5];
        word[ERR_MSG_BIT]       = flags[4];
        word[UR_CPL_BIT]        = flags[3];
        word[CA_RX_BIT]         = flags[2];
        word[CA_SIG_BIT]        = flags[1];
        word[MASTER_POISON_BIT] = flags[0];
        return word;
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic        status_write;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic        poisoned_rx_detected_ff;
    logic        error_message_signalled_ff;
    logic        unsupported_completion_received_ff;
    logic        completer_abort_received_ff;
    logic        completer_abort_signalled_ff;
    logic        master_poison_error_ff;
    logic        nxt_poisoned_rx_detected;
    logic        nxt_error_message_signalled;
    logic        nxt_unsupported_completion_received;
    logic        nxt_completer_abort_received;
    logic        nxt_completer_abort_signalled;
    logic        nxt_master_poison_error;
    logic [15:0] nxt_status;

    // ----------------------------------------
    // Event decode
    // ----------------------------------------
    always_comb begin
        set_vec = '0;
        set_vec[POISONED_RX_BIT] = poisoned_tlp_rx_in;
        set_vec[ERR_MSG_BIT]     = error_msg_sent_in & system_error_enable_in;
        set_vec[UR_CPL_BIT]      = ur_cpl_rx_in;
        set_vec[CA_RX_BIT]       = ca_cpl_rx_in;
        set_vec[CA_SIG_BIT]      = ca_cpl_sent_in;
        // Poison still forwarded downstream; enable only masks the flag
        set_vec[MASTER_POISON_BIT] = parity_response_enable_in
            & (poisoned_cpl_data_rx_in | write_req_poisoned_in);
    end

    // ----------------------------------------
    // Clear decode
    // ----------------------------------------
    assign status_write = cfg_wr_in & (cfg_addr_in == STATUS_OFFSET);

    always_comb begin
        clr_vec = '0;
        if (status_write) begin
            clr_vec[7:0]  = lane_clear(cfg_be_in[0], cfg_wdata_in[7:0]);
            clr_vec[15:8] = lane_clear(cfg_be_in[1], cfg_wdata_in[15:8]);
        end
        // Read-only bits ignore the written ones
        clr_vec = clr_vec & STATUS_W1C_MASK;
    end

    // ----------------------------------------
    // Next flag values
    // ----------------------------------------
    assign nxt_poisoned_rx_detected = next_flag(poisoned_rx_detected_ff,
        set_vec[POISONED_RX_BIT], clr_vec[POISONED_RX_BIT]);
    assign nxt_error_message_signalled = next_flag(error_message_signalled_ff,
        set_vec[ERR_MSG_BIT], clr_vec[ERR_MSG_BIT]);
    assign nxt_unsupported_completion_received = next_flag(
        unsupported_completion_received_ff,
        set_vec[UR_CPL_BIT], clr_vec[UR_CPL_BIT]);
    assign nxt_completer_abort_received = next_flag(completer_abort_received_ff,
        set_vec[CA_RX_BIT], clr_vec[CA_RX_BIT]);
    assign nxt_completer_abort_signalled = next_flag(completer_abort_signalled_ff,
        set_vec[CA_SIG_BIT], clr_vec[CA_SIG_BIT]);
    assign nxt_master_poison_error = next_flag(master_poison_error_ff,
        set_vec[MASTER_POISON_BIT], clr_vec[MASTER_POISON_BIT]);

    // ----------------------------------------
    // Detected poison flag
    // ----------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            poisoned_rx_detected_ff <= STATUS_RESET[POISONED_RX_BIT];
        end else begin
            poisoned_rx_detected_ff <= nxt_poisoned_rx_detected;
        end
    end

    // ----------------------------------------
    // Error message flag
    // ----------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            error_message_signalled_ff <= STATUS_RESET[ERR_MSG_BIT];
        end else begin
            error_message_signalled_ff <= nxt_error_message_signalled;
        end
    end

    // ----------------------------------------
    // Unsupported completion flag
    // ----------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            unsupported_completion_received_ff <= STATUS_RESET[UR_CPL_BIT];
        end else begin
            unsupported_completion_received_ff <= nxt_unsupported_completion_received;
        end
    end

    // ----------------------------------------
    // Completer abort received flag
    // ----------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            completer_abort_received_ff <= STATUS_RESET[CA_RX_BIT];
        end else begin
            completer_abort_received_ff <= nxt_completer_abort_received;
        end
    end

    // ----------------------------------------
    // Completer abort signalled flag
    // ----------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            completer_abort_signalled_ff <= STATUS_RESET[CA_SIG_BIT];
        end else begin
            completer_abort_signalled_ff <= nxt_completer_abort_signalled;
        end
    end

    // ----------------------------------------
    // Master poison flag
    // ----------------------------------------
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            master_poison_error_ff <= STATUS_RESET[MASTER_POISON_BIT];
        end else begin
            master_poison_error_ff <= nxt_master_poison_error;
        end
    end

    // ----------------------------------------
    // Read value, registered
    // ----------------------------------------
    // Built from next values so the read shows a change on the same edge
    assign nxt_status = pack_status({nxt_poisoned_rx_detected,
                                     nxt_error_message_signalled,
                                     nxt_unsupported_completion_received,
                                     nxt_completer_abort_received,
                                     nxt_completer_abort_signalled,
                                     nxt_master_poison_error});

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            status_out <= STATUS_RESET;
        end else begin
            status_out <= nxt_status;
        end
    end
endmodule // pbs_status_reg
`default_nettype wire

// *** bench/pbs_status_reg_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module pbs_chk (input wire logic core_clk_in, rstn_in, cfg_wr_in, poisoned_tlp_rx_in,
    ur_cpl_rx_in, ca_cpl_rx_in, ca_cpl_sent_in, system_error_enable_in,
    parity_response_enable_in, input wire logic [15:0] status_out);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    let s = status_out;
    a_poison_set: assert property (poisoned_tlp_rx_in |=> s[15]) else $error("unset");
    a_ur_set: assert property (ur_cpl_rx_in |=> s[13]) else $error("unset");
    a_ca_rx_set: assert property (ca_cpl_rx_in |=> s[12]) else $error("unset");
    a_ca_sig_set: assert property (ca_cpl_sent_in |=> s[11]) else $error("unset");
    a_se_gate: assert property (!system_error_enable_in && !s[14] |=> !s[14])
        else $error("stray flag");
    a_pe_gate: assert property (!parity_response_enable_in && !s[8] |=> !s[8])
        else $error("stray flag");
    a_tied_bits: assert property ((s & 16'h06FF) == 16'h0010)
        else $error("tied bits");
    a_flag_hold: assert property (!cfg_wr_in |=> !($past(s) & ~s)) else $error("lost");
    cover property ($rose(s[15]));
    cover property ($fell(s[13]));
    cover property (cfg_wr_in && poisoned_tlp_rx_in);
endmodule // pbs_chk
`default_nettype wire

// *** bench/pbs_link_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module pbs_link_model (input wire logic core_clk_in, output logic [6:0] ev_out);
    initial ev_out = 7'h00;
    task automatic fire(input logic [6:0] e);
        @(posedge core_clk_in) ev_out <= e;
        @(posedge core_clk_in) ev_out <= 7'h00;
    endtask
endmodule // pbs_link_model
`default_nettype wire

// *** bench/tb_pbs_status_reg.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_pbs_status_reg;
    import pbs_pkg::*;
    logic        core_clk_in = 0, rstn_in = 0, cfg_wr_in = 0;
    logic        parity_response_enable_in = 1, system_error_enable_in = 1;
    logic [1:0]  cfg_be_in = 2'h0;
    logic [7:0]  cfg_addr_in = 8'h00;
    logic [15:0] cfg_wdata_in = 16'h0000, status_out;
    logic [6:0]  ev;
    int          fail_count = 0, n_checks = 0, pos [7] = '{15, 8, 8, 14, 13, 12, 11};
    pbs_status_reg u_dut (.*, .poisoned_tlp_rx_in(ev[0]), .poisoned_cpl_data_rx_in(ev[1]),
        .write_req_poisoned_in(ev[2]), .error_msg_sent_in(ev[3]), .ur_cpl_rx_in(ev[4]),
        .ca_cpl_rx_in(ev[5]), .ca_cpl_sent_in(ev[6]));
    pbs_link_model u_link (.core_clk_in, .ev_out(ev));
    initial forever #4 core_clk_in = ~core_clk_in;
    initial begin repeat (3000) @(posedge core_clk_in); fail_count++; complete_run(); end
    task automatic wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
        @(posedge core_clk_in) {cfg_wr_in, cfg_addr_in, cfg_be_in, cfg_wdata_in} <= {1'b1,a,b,d};
        @(posedge core_clk_in) cfg_wr_in <= 1'b0;
    endtask
    task automatic chk(input logic [15:0] e);
        #1 n_checks++;
        fail_count += int'(status_out !== e);
        if (status_out !== e) $display("mismatch %0t got %h exp %h", $time, status_out, e);
    endtask
    task automatic complete_run;
        if (fail_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        chk(STATUS_RESET);
        for (int i = 0; i < 7; i++) begin
            u_link.fire(7'(1 << i));
            chk(STATUS_RESET | (16'h0001 << pos[i]));
            wr(STATUS_OFFSET, 2'h3, 16'hFFFF);
            chk(STATUS_RESET);
        end
        @(posedge core_clk_in) {parity_response_enable_in, system_error_enable_in} <= 2'b00;
        u_link.fire(7'h7F);
        // Wrong offset, low lane only, zeros on flags: none may clear
        wr(CMD_OFFSET, 2'h3, 16'hFFFF);
        wr(STATUS_OFFSET, 2'h1, 16'hFFFF);
        wr(STATUS_OFFSET, 2'h3, 16'h06FF);
        chk(16'hB810);
        fork u_link.fire(7'h01); wr(STATUS_OFFSET, 2'h2, 16'hFFFF); join
        chk(16'h8010);
        complete_run();
    end
endmodule // tb_pbs_status_reg
bind pbs_status_reg pbs_chk u_chk (.*);
`default_nettype wire
